/* File: core/nibble_host_packet_port.sv */
// Purpose: device end of the 4-bit handshake packet port to a host
// Assumes: radio side supplies received bytes and preamble flags
// Notes: handshake pins and bus inputs are synchronised before use
//
// Overview of operation
// - each byte moves as two nibbles, low nibble first
// - a packet holds 1 to 28 bytes, control byte first
// - download: request low, accept low, request high, accept high
// - first request answered within 1ms, later nibbles quickly
// - requests ignored while receiving, granted after a failed reception
// - valid received packet is uploaded before a pending download
// - upload: request low, accept low, drive nibble request high, accept high
// - bus drivers turn off only after the last upload nibble
// - class bit clear means radio data packet, up to 27 user bytes
// - class bit set means memory access, bit 6 write, low bits address
// - read answers echo plus contents; write gets no reply
// - writes to 01 to 3F program nv storage, 10ms each
// - nv write needs unlock bit, cleared after each nv write
// - unlock not needed for reads or writes to address 00
// - operating_flags loads from nv location 08 at pin reset or timeout reset
// - power level bits pick continuous, programmable, fixed 2.9s, or off
// - host request wakes at once; listen settle plus 1ms, then sleep
// - programmable off time is 22ms doubled per code step
// - radio timeout resets after 2.9s plain preamble, not wake preamble
// - host timeout resets when host stalls a handshake for 2.9s
// - handshake lines active low, data lines true
// - bus high impedance between packets, driven from accept to end
`timescale 1ns/10ps
`include "nibble_port_defs.svh"
module nibble_host_packet_port #(
  parameter logic [31:0] INIT_CYCLES = `INIT_CYCLES,
  parameter logic [31:0] TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
  parameter logic [31:0] OFF_BASE_CYCLES = `OFF_BASE_CYCLES,
  parameter logic [31:0] LISTEN_EXTRA_CYCLES = `LISTEN_EXTRA_CYCLES,
  parameter logic [31:0] NV_WRITE_CYCLES = `NV_WRITE_CYCLES
) (
  // clock and resets
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_power_on_n,
  // host handshake pins, active low
  input wire logic i_host_send_request_n,
  output logic o_host_send_accept_n,
  output logic o_device_send_request_n,
  input wire logic i_device_send_accept_n,
  // nibble bus, nibble_line_0 is bit 0
  input wire logic [3:0] i_nibble,
  output logic [3:0] o_nibble,
  output logic o_nibble_oe,
  // bytes toward the transmitter
  output logic [7:0] o_tx_byte,
  output logic o_tx_valid,
  output logic o_tx_last,
  // bytes from the receiver
  input wire logic i_rx_busy,
  input wire logic i_rx_byte_valid,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_end,
  input wire logic i_rx_good,
  input wire logic i_preamble,
  input wire logic i_wake_preamble,
  // power and status
  output logic o_rx_enable,
  output logic o_self_reset,
  output logic [7:0] o_operating_flags
);
  nibble_port_pkg::port_state_t state_reg, st_prev_reg;
  nibble_port_pkg::pwr_state_t pwr_reg;
  logic [5:0] sync1_reg, sync2_reg;
  logic [7:0] flags_reg, ctrl_reg, rx_buf [0:`MAX_PACKET_BYTES-1];
  logic [3:0] dl_lo_reg;
  logic dl_phase_reg, dl_last_reg, ul_phase_reg, ul_mem_reg, rx_pending_reg, nv_wr_reg;
  logic [4:0] dl_cnt_reg, dl_need_reg, ul_idx_reg, rx_ptr_reg, rx_len_reg;
  logic [7:0] nv_wdata_reg;
  logic [31:0] init_cnt_reg, hto_cnt_reg, rto_cnt_reg, pwr_cnt_reg;
  logic rst;
  logic [7:0] nv_rd_data, nv_settle, nv_boot;
  logic [2:0] nv_sleep_code;
  logic nv_busy;

  // two-stage synchroniser per async input bit; one vector keeps every index in range
  wire [5:0] async_in = {i_device_send_accept_n, i_host_send_request_n, i_nibble};
  for (genvar b = 0; b < 6; b++) begin : g_sync
    always_ff @(posedge i_clk) begin
      sync1_reg[b] <= async_in[b];
      sync2_reg[b] <= sync1_reg[b];
    end
  end
  wire [3:0] nib_s = sync2_reg[3:0];
  wire hsr_low = !sync2_reg[4];
  wire dsa_low = !sync2_reg[5];

  // internal reset: pin or a timeout
  assign rst = !i_resetn || o_self_reset;
  assign o_operating_flags = flags_reg;

  // download byte decode
  wire [7:0] dl_byte = {nib_s, dl_lo_reg};
  wire [4:0] user_len = (dl_byte[4:0] > `MAX_USER_BYTES) ? `MAX_USER_BYTES : dl_byte[4:0];
  wire [4:0] first_need = dl_byte[`CLASS_BIT] ? (dl_byte[`WRITE_BIT] ? 5'h02 : 5'h01)
                                              : 5'(user_len + 5'h01);
  wire [4:0] dl_need = (dl_cnt_reg == 5'h00) ? first_need : dl_need_reg;
  wire dl_is_data = (dl_cnt_reg == 5'h00) ? !dl_byte[`CLASS_BIT] : !ctrl_reg[`CLASS_BIT];
  wire dl_byte_last = (5'(dl_cnt_reg + 5'h01) == dl_need);
  wire mem_wr_byte = (dl_cnt_reg == 5'h01) && ctrl_reg[`CLASS_BIT] && ctrl_reg[`WRITE_BIT];
  wire [5:0] mem_addr = ctrl_reg[5:0];
  wire mem_rd_pkt = ctrl_reg[`CLASS_BIT] && !ctrl_reg[`WRITE_BIT];

  // upload byte select: echo then contents, or the radio buffer
  wire [7:0] mem_rd_val = (mem_addr == `FLAGS_ADDR) ? flags_reg : nv_rd_data;
  wire [7:0] ul_byte = ul_mem_reg ? ((ul_idx_reg == 5'h00) ? ctrl_reg : mem_rd_val)
                                  : rx_buf[ul_idx_reg];
  wire [4:0] ul_total = ul_mem_reg ? 5'h02 : rx_len_reg;
  wire ul_last = ul_phase_reg && (5'(ul_idx_reg + 5'h01) == ul_total);
  wire dl_start_ok = hsr_low && !i_rx_busy && !nv_busy;

  // handshake state machine
  always_ff @(posedge i_clk) begin
    if (rst) begin
      state_reg <= nibble_port_pkg::ST_INIT;
      o_host_send_accept_n <= 1'b1;
      o_device_send_request_n <= 1'b1;
      o_nibble_oe <= 1'b0;
      o_nibble <= 4'h0;
      dl_phase_reg <= 1'b0;
      dl_cnt_reg <= 5'h00;
      dl_last_reg <= 1'b0;
      ul_phase_reg <= 1'b0;
      ul_idx_reg <= 5'h00;
      ul_mem_reg <= 1'b0;
      init_cnt_reg <= 32'h0;
    end else begin
      case (state_reg)
        nibble_port_pkg::ST_INIT: begin
          // host requests are not looked at until the flags are loaded
          init_cnt_reg <= init_cnt_reg + 32'h1;
          if (init_cnt_reg == INIT_CYCLES - 32'h1) begin
            state_reg <= nibble_port_pkg::ST_IDLE;
          end
        end
        nibble_port_pkg::ST_IDLE: begin
          dl_cnt_reg <= 5'h00;
          dl_phase_reg <= 1'b0;
          if (rx_pending_reg) begin
            ul_mem_reg <= 1'b0;
            ul_idx_reg <= 5'h00;
            ul_phase_reg <= 1'b0;
            o_device_send_request_n <= 1'b0;
            state_reg <= nibble_port_pkg::ST_UL_REQ;
          end else if (dl_start_ok) begin
            o_host_send_accept_n <= 1'b0;
            state_reg <= nibble_port_pkg::ST_DL_ACC;
          end
        end
        nibble_port_pkg::ST_DL_ACC: begin
          if (!hsr_low) begin
            o_host_send_accept_n <= 1'b1;
            dl_phase_reg <= !dl_phase_reg;
            dl_lo_reg <= nib_s;
            if (dl_phase_reg) begin
              dl_cnt_reg <= 5'(dl_cnt_reg + 5'h01);
              dl_last_reg <= dl_byte_last;
            end else begin
              dl_last_reg <= 1'b0;
            end
            state_reg <= nibble_port_pkg::ST_DL_REL;
          end
        end
        nibble_port_pkg::ST_DL_REL: begin
          if (dl_last_reg && mem_rd_pkt) begin
            ul_mem_reg <= 1'b1;
            ul_idx_reg <= 5'h00;
            ul_phase_reg <= 1'b0;
            o_device_send_request_n <= 1'b0;
            state_reg <= nibble_port_pkg::ST_UL_REQ;
          end else if (dl_last_reg) begin
            state_reg <= nibble_port_pkg::ST_IDLE;
          end else if (hsr_low) begin
            o_host_send_accept_n <= 1'b0;
            state_reg <= nibble_port_pkg::ST_DL_ACC;
          end
        end
        nibble_port_pkg::ST_UL_REQ: begin
          if (dsa_low) begin
            o_nibble_oe <= 1'b1;
            o_nibble <= ul_phase_reg ? ul_byte[7:4] : ul_byte[3:0];
            o_device_send_request_n <= 1'b1;
            state_reg <= nibble_port_pkg::ST_UL_PUT;
          end
        end
        nibble_port_pkg::ST_UL_PUT: begin
          if (!dsa_low) begin
            ul_phase_reg <= !ul_phase_reg;
            if (ul_phase_reg) begin
              ul_idx_reg <= 5'(ul_idx_reg + 5'h01);
            end
            if (ul_last) begin
              o_nibble_oe <= 1'b0;
              state_reg <= nibble_port_pkg::ST_IDLE;
            end else begin
              o_device_send_request_n <= 1'b0;
              state_reg <= nibble_port_pkg::ST_UL_REQ;
            end
          end
        end
        default: state_reg <= nibble_port_pkg::ST_IDLE;
      endcase
    end
  end

  // completed download bytes: transmitter stream and memory writes
  wire byte_done = (state_reg == nibble_port_pkg::ST_DL_ACC) && !hsr_low && dl_phase_reg;
  wire nv_target = (mem_addr != `FLAGS_ADDR) && (mem_addr <= `NV_LAST_ADDR);
  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_tx_valid <= 1'b0;
      o_tx_last <= 1'b0;
      o_tx_byte <= 8'h00;
      ctrl_reg <= 8'h00;
      dl_need_reg <= 5'h01;
      nv_wr_reg <= 1'b0;
      nv_wdata_reg <= 8'h00;
    end else begin
      o_tx_valid <= byte_done && dl_is_data;
      o_tx_last <= byte_done && dl_is_data && dl_byte_last;
      nv_wr_reg <= byte_done && mem_wr_byte && nv_target && flags_reg[`UNLOCK_BIT];
      if (byte_done) begin
        o_tx_byte <= dl_byte;
        nv_wdata_reg <= dl_byte;
        if (dl_cnt_reg == 5'h00) begin
          ctrl_reg <= dl_byte;
          dl_need_reg <= first_need;
        end
      end
    end
  end

  // operating_flags: loaded from nv at every pin or timeout reset, written at address 00
  always_ff @(posedge i_clk) begin
    if (rst) begin
      flags_reg <= `FLAGS_RESET;
    end else if ((state_reg == nibble_port_pkg::ST_INIT) && (init_cnt_reg == 32'h1)) begin
      flags_reg <= nv_boot;
    end else if (byte_done && mem_wr_byte && (mem_addr == `FLAGS_ADDR)) begin
      flags_reg <= dl_byte;
    end else if (nv_wr_reg) begin
      flags_reg[`UNLOCK_BIT] <= 1'b0;
    end
  end

  // received packet buffer; a new pending packet wins over the clear
  wire ul_done = (state_reg == nibble_port_pkg::ST_UL_PUT) && !dsa_low && ul_last;
  always_ff @(posedge i_clk) begin
    if (rst) begin
      rx_ptr_reg <= 5'h00;
      rx_len_reg <= 5'h00;
      rx_pending_reg <= 1'b0;
    end else begin
      if (i_rx_byte_valid && !rx_pending_reg && (rx_ptr_reg < 5'(`MAX_PACKET_BYTES))) begin
        rx_buf[rx_ptr_reg] <= i_rx_byte;
        rx_ptr_reg <= 5'(rx_ptr_reg + 5'h01);
      end
      if (i_rx_end) begin
        rx_ptr_reg <= 5'h00;
      end
      if (i_rx_end && i_rx_good && !rx_pending_reg && (rx_ptr_reg != 5'h00)) begin
        rx_pending_reg <= 1'b1;
        rx_len_reg <= rx_ptr_reg;
      end else if (ul_done && !ul_mem_reg) begin
        rx_pending_reg <= 1'b0;
      end
    end
  end

  // host and radio watchdogs; a stall in any handshake wait counts
  wire host_wait = (state_reg != nibble_port_pkg::ST_INIT) &&
                   (state_reg != nibble_port_pkg::ST_IDLE);
  wire plain_pre = i_preamble && !i_wake_preamble;
  always_ff @(posedge i_clk) begin
    st_prev_reg <= state_reg;
    if (rst) begin
      hto_cnt_reg <= 32'h0;
      rto_cnt_reg <= 32'h0;
    end else begin
      hto_cnt_reg <= (host_wait && (st_prev_reg == state_reg)) ? hto_cnt_reg + 32'h1 : 32'h0;
      rto_cnt_reg <= plain_pre ? rto_cnt_reg + 32'h1 : 32'h0;
    end
  end
  wire hto_fire = flags_reg[`HTO_BIT] && (hto_cnt_reg >= TIMEOUT_CYCLES);
  wire rto_fire = flags_reg[`RTO_BIT] && (rto_cnt_reg > TIMEOUT_CYCLES);
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_self_reset <= 1'b0;
    end else begin
      o_self_reset <= !o_self_reset && (hto_fire || rto_fire);
    end
  end

  // idle power control; off time only while nothing is happening
  wire [1:0] ps = {flags_reg[`PS1_BIT], flags_reg[`PS0_BIT]};
  wire [31:0] listen_cycles = 32'(nv_settle) * 32'(`SETTLE_UNIT_CYCLES) + LISTEN_EXTRA_CYCLES;
  wire [31:0] off_cycles = (ps == 2'b01) ? (OFF_BASE_CYCLES << nv_sleep_code)
                                         : TIMEOUT_CYCLES;
  wire busy_any = host_wait || hsr_low || rx_pending_reg || i_rx_busy;
  always_ff @(posedge i_clk) begin
    if (rst) begin
      pwr_reg <= nibble_port_pkg::PW_LISTEN;
      pwr_cnt_reg <= 32'h0;
    end else begin
      case (pwr_reg)
        nibble_port_pkg::PW_LISTEN: begin
          if (busy_any || i_preamble || (ps == 2'b00)) begin
            pwr_cnt_reg <= 32'h0;
          end else if (pwr_cnt_reg >= listen_cycles) begin
            pwr_cnt_reg <= 32'h0;
            pwr_reg <= nibble_port_pkg::PW_OFF;
          end else begin
            pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
          end
        end
        nibble_port_pkg::PW_OFF: begin
          // a host request or a change to mode 00 wakes at once; mode 11 never times out
          if (busy_any || (ps == 2'b00) ||
              ((ps != 2'b11) && (pwr_cnt_reg >= off_cycles))) begin
            pwr_cnt_reg <= 32'h0;
            pwr_reg <= nibble_port_pkg::PW_LISTEN;
          end else begin
            pwr_cnt_reg <= pwr_cnt_reg + 32'h1;
          end
        end
        default: pwr_reg <= nibble_port_pkg::PW_LISTEN;
      endcase
    end
  end
  assign o_rx_enable = (pwr_reg != nibble_port_pkg::PW_OFF);

  // nv storage
  nv_store #(.WRITE_CYCLES(NV_WRITE_CYCLES)) u_nv (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_power_on_n(i_power_on_n),
    .i_wr(nv_wr_reg),
    .i_addr(mem_addr),
    .i_data(nv_wdata_reg),
    .o_busy(nv_busy),
    .i_rd_addr(mem_addr),
    .o_rd_data(nv_rd_data),
    .o_sleep_code(nv_sleep_code),
    .o_settle(nv_settle),
    .o_boot_flags(nv_boot)
  );

  // checks
  chk_accept_after_req: assert property (@(posedge i_clk) disable iff (rst)
    $fell(o_host_send_accept_n) |-> $past(hsr_low) && !$past(i_rx_busy))
    else $error("accept without a synced request");
  chk_pending_first: assert property (@(posedge i_clk) disable iff (rst)
    (state_reg == nibble_port_pkg::ST_IDLE) && rx_pending_reg |=> !o_device_send_request_n
      && o_host_send_accept_n)
    else $error("pending packet not offered first");
  chk_oe_held_upload: assert property (@(posedge i_clk) disable iff (rst)
    (state_reg == nibble_port_pkg::ST_UL_PUT) && !ul_last |=> o_nibble_oe)
    else $error("bus released before last nibble");
  chk_low_nibble_first: assert property (@(posedge i_clk) disable iff (rst)
    $rose(o_nibble_oe) |-> (o_nibble == $past(ul_byte[3:0])))
    else $error("upload did not start with low nibble");
  chk_nv_unlock: assert property (@(posedge i_clk) disable iff (rst)
    nv_wr_reg |-> $past(flags_reg[`UNLOCK_BIT]) ##1 !flags_reg[`UNLOCK_BIT])
    else $error("nv write without unlock or unlock kept");
  chk_no_idle_oe: assert property (@(posedge i_clk) disable iff (rst)
    (state_reg == nibble_port_pkg::ST_IDLE) && $past(state_reg == nibble_port_pkg::ST_IDLE)
      |-> !o_nibble_oe)
    else $error("bus driven between packets");
  chk_host_wakes: assert property (@(posedge i_clk) disable iff (rst)
    (pwr_reg == nibble_port_pkg::PW_OFF) && hsr_low |=> o_rx_enable)
    else $error("host request did not wake");
  chk_host_timeout: assert property (@(posedge i_clk) disable iff (!i_resetn)
    hto_fire && !o_self_reset |=> o_self_reset)
    else $error("host timeout did not reset");
  chk_flags_boot: assert property (@(posedge i_clk) disable iff (rst)
    (state_reg == nibble_port_pkg::ST_INIT) && (init_cnt_reg == 32'h1) |=>
      (flags_reg == $past(nv_boot)))
    else $error("flags not loaded from nv");
endmodule : nibble_host_packet_port

/* File: core/nibble_port_defs.svh */
// Purpose: shared constants for the nibble host packet port
// Assumes: 25 MHz core clock
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef NIBBLE_PORT_DEFS_SVH
`define NIBBLE_PORT_DEFS_SVH

`define CLK_KHZ 25000
// memory map
`define FLAGS_ADDR 6'h00
`define SLEEP_CODE_ADDR 6'h03
`define SETTLE_ADDR 6'h05
`define BOOT_FLAGS_ADDR 6'h08
`define NV_LAST_ADDR 6'h3F
`define FLAGS_RESET 8'h00
// nv defaults for the parameter area
`define NV_DEF_01 8'hA0
`define NV_DEF_02 8'hFF
`define NV_DEF_03 8'h05
`define NV_DEF_04 8'h1E
`define NV_DEF_05 8'h1E
`define NV_DEF_06 8'h03
`define NV_DEF_07 8'h01
`define NV_DEF_OTHER 8'h00
// control byte fields
`define CLASS_BIT 7
`define WRITE_BIT 6
`define MAX_PACKET_BYTES 28
`define MAX_USER_BYTES 5'd27
// operating_flags fields
`define PS0_BIT 0
`define PS1_BIT 1
`define RTO_BIT 2
`define HTO_BIT 3
`define UNLOCK_BIT 4
// timing
`define INIT_TIME_MS 1
`define INIT_CYCLES (`INIT_TIME_MS * `CLK_KHZ)
`define NV_WRITE_MS 10
`define NV_WRITE_CYCLES (`NV_WRITE_MS * `CLK_KHZ)
`define TIMEOUT_MS 2900
`define TIMEOUT_CYCLES (`TIMEOUT_MS * `CLK_KHZ)
`define OFF_BASE_MS 22
`define OFF_BASE_CYCLES (`OFF_BASE_MS * `CLK_KHZ)
`define LISTEN_EXTRA_MS 1
`define LISTEN_EXTRA_CYCLES (`LISTEN_EXTRA_MS * `CLK_KHZ)
`define SETTLE_UNIT_US 100
`define SETTLE_UNIT_CYCLES ((`SETTLE_UNIT_US * `CLK_KHZ) / 1000)

`endif

/* File: core/nibble_port_pkg.sv */
// Purpose: state types for the nibble host packet port
// Assumes: nothing
// Notes: constants live in nibble_port_defs.svh
package nibble_port_pkg;
  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_DL_ACC, ST_DL_REL, ST_UL_REQ, ST_UL_PUT
  } port_state_t;
  typedef enum logic [1:0] {PW_LISTEN, PW_OFF} pwr_state_t;
endpackage : nibble_port_pkg

/* File: core/nv_store.sv */
// Purpose: 64-byte non-volatile store with write-busy timing
// Assumes: one write at a time, caller waits while busy
// Notes: contents survive i_resetn, only power-on loads defaults
`timescale 1ns/10ps
`include "nibble_port_defs.svh"
module nv_store #(
  parameter logic [31:0] WRITE_CYCLES = `NV_WRITE_CYCLES
) (
  // clock and resets
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_power_on_n,
  // write port
  input wire logic i_wr,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_data,
  output logic o_busy,
  // read ports
  input wire logic [5:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  output logic [2:0] o_sleep_code,
  output logic [7:0] o_settle,
  output logic [7:0] o_boot_flags
);
  logic [7:0] mem [0:63];
  logic [31:0] busy_reg;

  function automatic logic [7:0] nv_default(input logic [5:0] a);
    case (a)
      6'h01: nv_default = `NV_DEF_01;
      6'h02: nv_default = `NV_DEF_02;
      6'h03: nv_default = `NV_DEF_03;
      6'h04: nv_default = `NV_DEF_04;
      6'h05: nv_default = `NV_DEF_05;
      6'h06: nv_default = `NV_DEF_06;
      6'h07: nv_default = `NV_DEF_07;
      default: nv_default = `NV_DEF_OTHER;
    endcase
  endfunction : nv_default

  // storage cells, one generate entry per byte
  for (genvar g = 0; g < 64; g++) begin : g_cell
    always_ff @(posedge i_clk) begin
      if (!i_power_on_n) begin
        mem[g] <= nv_default(6'(g));
      end else if (i_wr && !o_busy && (i_addr == 6'(g))) begin
        mem[g] <= i_data;
      end
    end
  end

  // write busy for the full programming time
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_power_on_n) begin
      busy_reg <= 32'h0;
    end else if (i_wr && !o_busy) begin
      busy_reg <= WRITE_CYCLES;
    end else if (busy_reg != 32'h0) begin
      busy_reg <= busy_reg - 32'h1;
    end
  end
  assign o_busy = (busy_reg != 32'h0);

  // registered reads, one cycle late
  always_ff @(posedge i_clk) begin
    o_rd_data <= mem[i_rd_addr];
    o_sleep_code <= mem[`SLEEP_CODE_ADDR][2:0];
    o_settle <= mem[`SETTLE_ADDR];
    o_boot_flags <= mem[`BOOT_FLAGS_ADDR];
  end
endmodule : nv_store

/* File: dv/host_model.sv */
// Purpose: host side of the nibble port, both transfer directions
// Assumes: pins change at the falling clock edge
// Notes: bounded waits count hangs instead of stopping the run
`timescale 1ns/10ps
module host_model (
  // clock
  input wire logic i_clk,
  // handshake pins, active low
  input wire logic i_accept_n,
  input wire logic i_dev_req_n,
  output logic o_req_n,
  output logic o_dev_acc_n,
  // nibble bus
  input wire logic [3:0] i_bus,
  output logic [3:0] o_bus,
  output logic o_bus_oe
);
  int hang_cnt = 0;

  // request held high through device init, bus left as input
  initial begin
    o_req_n = 1'b1;
    o_dev_acc_n = 1'b1;
    o_bus = 4'h0;
    o_bus_oe = 1'b0;
  end

  // wait for a device pin level; a lost handshake counts as a hang
  task automatic wait_pin(input bit dev, input logic lvl);
    int n;
    n = 0;
    while (((dev ? i_dev_req_n : i_accept_n) !== lvl) && n < 4000) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 4000) hang_cnt++;
  endtask : wait_pin

  // data goes out only once accept is seen, held until accept rises
  task automatic put_nib(input logic [3:0] d);
    @(negedge i_clk) o_req_n = 1'b0;
    wait_pin(1'b0, 1'b0);
    @(negedge i_clk) o_bus_oe = 1'b1;
    o_bus = d;
    o_req_n = 1'b1;
    wait_pin(1'b0, 1'b1);
  endtask : put_nib

  task automatic put_byte(input logic [7:0] b);
    put_nib(b[3:0]);
    put_nib(b[7:4]);
  endtask : put_byte

  // bus back to input only after the whole packet
  task automatic release_bus();
    @(negedge i_clk) o_bus_oe = 1'b0;
  endtask : release_bus

  task automatic get_nib(output logic [3:0] d);
    wait_pin(1'b1, 1'b0);
    @(negedge i_clk) o_dev_acc_n = 1'b0;
    wait_pin(1'b1, 1'b1);
    d = i_bus;
    @(negedge i_clk) o_dev_acc_n = 1'b1;
  endtask : get_nib

  task automatic get_byte(output logic [7:0] b);
    get_nib(b[3:0]);
    get_nib(b[7:4]);
  endtask : get_byte
endmodule : host_model

/* File: dv/testbench.sv */
// Purpose: self-checking bench for the nibble host packet port
// Assumes: shortened init, timeout and nv write counts
// Notes: radio side and preamble inputs driven by hand
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic power_on_n = 1'b0;
  logic rx_busy = 1'b0, rx_vld = 1'b0, rx_end = 1'b0, rx_good = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic pre = 1'b0, wake = 1'b0;
  wire accept_n, dev_req_n, req_n, dev_acc_n, dev_oe, host_oe, tx_valid, tx_last;
  wire rx_en, self_rst;
  wire [3:0] dev_d, host_d, bus;
  wire [7:0] tx_byte, flags;
  int err_total = 0, total_checks = 0, cycles = 0, seed = 32'h09a5f9dd, rst_cnt = 0;
  logic [7:0] txq[$], exp_q[$];
  logic [7:0] b, v;
  logic last_seen = 1'b0;

  // weak pull-ups hold the bus high when nobody drives it
  assign bus = dev_oe ? dev_d : (host_oe ? host_d : 4'hF);

  nibble_host_packet_port #(.INIT_CYCLES(32'd20), .TIMEOUT_CYCLES(32'd200),
    .OFF_BASE_CYCLES(32'd16), .LISTEN_EXTRA_CYCLES(32'd10),
    .NV_WRITE_CYCLES(32'd30)) DUT (
    .i_clk(clk), .i_resetn(resetn), .i_power_on_n(power_on_n),
    .i_host_send_request_n(req_n), .o_host_send_accept_n(accept_n),
    .o_device_send_request_n(dev_req_n), .i_device_send_accept_n(dev_acc_n),
    .i_nibble(bus), .o_nibble(dev_d), .o_nibble_oe(dev_oe),
    .o_tx_byte(tx_byte), .o_tx_valid(tx_valid), .o_tx_last(tx_last),
    .i_rx_busy(rx_busy), .i_rx_byte_valid(rx_vld), .i_rx_byte(rx_byte),
    .i_rx_end(rx_end), .i_rx_good(rx_good), .i_preamble(pre),
    .i_wake_preamble(wake), .o_rx_enable(rx_en), .o_self_reset(self_rst),
    .o_operating_flags(flags));

  host_model host (.i_clk(clk), .i_accept_n(accept_n), .i_dev_req_n(dev_req_n),
    .o_req_n(req_n), .o_dev_acc_n(dev_acc_n), .i_bus(bus), .o_bus(host_d),
    .o_bus_oe(host_oe));

  initial forever #20 clk = ~clk;

  // collect the transmit stream; cycle ceiling cuts a hang short
  always @(negedge clk) begin
    cycles++;
    if (self_rst === 1'b1) rst_cnt++;
    if (tx_valid === 1'b1) begin
      txq.push_back(tx_byte);
      last_seen = tx_last;
    end
    if (cycles > 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    err_total += host.hang_cnt;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // download the queued packet whole, then free the bus
  task automatic dl();
    txq = {};
    foreach (exp_q[i]) host.put_byte(exp_q[i]);
    host.release_bus();
    repeat (8) @(negedge clk);
  endtask : dl

  // two-byte memory write
  task automatic wr(input logic [7:0] ctl, input logic [7:0] d);
    exp_q = '{ctl, d};
    dl();
  endtask : wr

  // memory read: echo first, then contents, drivers off afterwards
  task automatic rd(input logic [7:0] ctl, input logic [7:0] exp);
    exp_q = '{ctl};
    dl();
    host.get_byte(b);
    chk(b, ctl);
    host.get_byte(b);
    chk(b, exp);
    repeat (4) @(negedge clk);
    chk({7'h00, dev_oe}, 8'h00);
  endtask : rd

  task automatic radio_in(input logic good);
    foreach (exp_q[i]) begin
      @(negedge clk) rx_vld = 1'b1;
      rx_byte = exp_q[i];
      @(negedge clk) rx_vld = 1'b0;
    end
    @(negedge clk) rx_end = 1'b1;
    rx_good = good;
    @(negedge clk) rx_end = 1'b0;
    rx_busy = 1'b0;
  endtask : radio_in

  // main sequence: data, memory, refused request, upload
  initial begin
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    power_on_n = 1'b1;
    repeat (40) @(negedge clk);
    chk(flags, 8'h00);
    chk({7'h00, dev_oe}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 8'h00 : (k == 3) ? 8'h1B : (8'($random(seed)) & 8'h03);
      exp_q = '{v};
      for (int i = 0; i < int'(v); i++) exp_q.push_back(8'($random(seed)));
      dl();
      chk(8'(txq.size()), 8'(exp_q.size()));
      foreach (exp_q[i]) chk(txq[i], exp_q[i]);
      chk({7'h00, last_seen}, 8'h01);
    end
    exp_q = '{8'hC0, 8'h10};
    dl();
    chk(flags, 8'h10);
    chk(8'(txq.size()), 8'h00);
    v = 8'($random(seed));
    exp_q = '{8'hD0, v};
    dl();
    chk(flags, 8'h00);
    rd(8'h90, v);
    exp_q = '{8'hD0, ~v};
    dl();
    rd(8'h90, v);
    rd(8'h83, 8'h05);
    rd(8'h80, 8'h00);
    // request during a reception that fails its check
    rx_busy = 1'b1;
    exp_q = '{8'h01, 8'h5A};
    txq = {};
    fork
      host.put_byte(8'h00);
      begin
        repeat (12) @(negedge clk);
        chk({7'h00, accept_n}, 8'h01);
        radio_in(1'b0);
      end
    join
    host.release_bus();
    repeat (8) @(negedge clk);
    chk(8'(txq.size()), 8'h01);
    // valid reception goes up to the host
    exp_q = '{8'h02, 8'($random(seed)), 8'($random(seed))};
    rx_busy = 1'b1;
    radio_in(1'b1);
    foreach (exp_q[i]) begin
      host.get_byte(b);
      chk(b, exp_q[i]);
    end
    repeat (4) @(negedge clk);
    chk({7'h00, dev_oe}, 8'h00);
    // mode 11 sleeps after a short listen, a host request wakes it at once
    wr(8'hC0, 8'h10);
    wr(8'hC5, 8'h00);
    wr(8'hC0, 8'h03);
    repeat (30) @(negedge clk);
    chk({7'h00, rx_en}, 8'h00);
    fork
      host.put_byte(8'h00);
      begin
        repeat (4) @(negedge clk);
        chk({7'h00, rx_en}, 8'h01);
      end
    join
    host.release_bus();
    // radio timeout: wake preamble spares it, plain preamble resets and reloads
    wr(8'hC0, 8'h10);
    wr(8'hC8, 8'h20);
    wr(8'hC0, 8'h04);
    pre = 1'b1;
    wake = 1'b1;
    repeat (300) @(negedge clk);
    chk(flags, 8'h04);
    wake = 1'b0;
    repeat (300) @(negedge clk);
    pre = 1'b0;
    chk(8'(rst_cnt), 8'h01);
    chk(flags, 8'h20);
    // host timeout: an upload the host never takes resets the device
    wr(8'hC0, 8'h08);
    exp_q = '{8'h01, 8'h33};
    radio_in(1'b1);
    repeat (300) @(negedge clk);
    chk(8'(rst_cnt), 8'h02);
    chk({7'h00, dev_req_n}, 8'h01);
    stop_test();
  end
endmodule : testbench
